// ===== hdl/rgb_bridge.sv
// dual ddr/sdr bridge between gigabit phy pins and tile port sets
`timescale 1ns/1ps
`include "rgb_map.svh"
module rgb_bridge (
  // system clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // per-tile setup controls
  input wire logic [`RGB_TILES-1:0] adapter_enable,
  input wire logic [`RGB_TILES-1:0] tx_clock_run,
  input wire logic [`RGB_TILES-1:0] tx_clock_delay,
  input wire logic [`RGB_TILES-1:0] phy_release,
  // per-tile transmit port
  input wire logic [`RGB_TILES-1:0][`RGB_BYTE_W-1:0] tx_word,
  input wire logic [`RGB_TILES-1:0] tx_valid,
  input wire logic [`RGB_TILES-1:0] tx_error,
  output logic [`RGB_TILES-1:0] tx_take,
  // per-tile receive port
  output logic [`RGB_TILES-1:0][`RGB_BYTE_W-1:0] rx_word,
  output logic [`RGB_TILES-1:0] rx_valid,
  output logic [`RGB_TILES-1:0] rx_error,
  output logic [`RGB_TILES-1:0] rx_strobe,
  output logic [`RGB_TILES-1:0] rx_frame_end,
  // per-tile general purpose use of the pins
  input wire logic [`RGB_TILES-1:0][`RGB_TXPIN_W-1:0] gpio_out,
  input wire logic [`RGB_TILES-1:0][`RGB_TXPIN_W-1:0] gpio_oe,
  output logic [`RGB_TILES-1:0][`RGB_RXPIN_W-1:0] gpio_in,
  // transmit pins {clock, control, nibble msb..lsb}
  output logic [`RGB_TILES-1:0][`RGB_TXPIN_W-1:0] tx_pin_out,
  output logic [`RGB_TILES-1:0][`RGB_TXPIN_W-1:0] tx_pin_oe,
  // receive pins
  input wire logic [`RGB_TILES-1:0] rx_link_clk,
  input wire logic [`RGB_TILES-1:0] receive_control,
  input wire logic [`RGB_TILES-1:0][`RGB_NIB_W-1:0] receive_nibble,
  // phy reset
  output logic [`RGB_TILES-1:0] phy_reset_n
);

  // next phase of the transmit clock sequencer
  function automatic rgb_pkg::rgb_phase_t phase_step(input rgb_pkg::rgb_phase_t p);
    case (p)
      rgb_pkg::PH_LO0: phase_step = rgb_pkg::PH_LO1;
      rgb_pkg::PH_LO1: phase_step = rgb_pkg::PH_HI0;
      rgb_pkg::PH_HI0: phase_step = rgb_pkg::PH_HI1;
      rgb_pkg::PH_HI1: phase_step = rgb_pkg::PH_LO0;
      default: phase_step = rgb_pkg::PH_LO0;
    endcase
  endfunction

  // clock level for a phase; the delayed form lags a quarter period
  function automatic logic clock_level(input rgb_pkg::rgb_phase_t p, input logic dly);
    if (dly)
      clock_level = (p == rgb_pkg::PH_LO1) || (p == rgb_pkg::PH_HI0);
    else
      clock_level = (p == rgb_pkg::PH_LO0) || (p == rgb_pkg::PH_LO1);
  endfunction

  genvar t;
  for (t = 0; t < `RGB_TILES; t++)
  begin : g_tile
    rgb_pkg::rgb_phase_t phase_r;
    rgb_pkg::rgb_phase_t phase_nxt;
    logic running;
    logic load;
    logic [`RGB_BYTE_W-1:0] byte_r;
    logic [`RGB_BYTE_W-1:0] byte_nxt;
    logic ok_r;
    logic bad_r;
    logic ok_nxt;
    logic bad_nxt;
    logic lo_half;
    logic [`RGB_TXPIN_W-1:0] drive_nxt;

    assign running = adapter_enable[t] && tx_clock_run[t];
    // idle in the last phase: the first edge of a run takes a byte, no runt clock pulse
    assign phase_nxt = running ? phase_step(phase_r) : rgb_pkg::PH_HI1;
    // a new byte is taken as each transmit clock period begins
    assign load = running && (phase_nxt == rgb_pkg::PH_LO0);
    assign byte_nxt = load ? tx_word[t] : byte_r;
    assign ok_nxt = load ? tx_valid[t] : ok_r;
    assign bad_nxt = load ? tx_error[t] : bad_r;
    assign lo_half = (phase_nxt == rgb_pkg::PH_LO0) || (phase_nxt == rgb_pkg::PH_LO1);

    // pin image: {clock, control, nibble}
    always_comb
    begin
      drive_nxt = '0;
      if (running)
      begin
        drive_nxt[`RGB_PIN_CLK] = clock_level(phase_nxt, tx_clock_delay[t]);
        drive_nxt[`RGB_PIN_CTL] = lo_half ? ok_nxt : (ok_nxt ^ bad_nxt);
        drive_nxt[`RGB_NIB_W-1:0] = lo_half ? byte_nxt[`RGB_NIB_W-1:0]
                                            : byte_nxt[`RGB_BYTE_W-1:`RGB_NIB_W];
      end
    end

    // transmit data path sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        phase_r <= rgb_pkg::PH_HI1;
        byte_r <= 8'h00;
        ok_r <= 1'b0;
        bad_r <= 1'b0;
        tx_take[t] <= 1'b0;
      end
      else
      begin
        phase_r <= phase_nxt;
        byte_r <= byte_nxt;
        ok_r <= ok_nxt;
        bad_r <= bad_nxt;
        tx_take[t] <= load;
      end
    end

    // pins belong to the bridge only while enabled
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        tx_pin_out[t] <= 6'h00;
        tx_pin_oe[t] <= 6'h00;
      end
      else if (adapter_enable[t])
      begin
        tx_pin_out[t] <= drive_nxt;
        tx_pin_oe[t] <= `RGB_OE_ALL;
      end
      else
      begin
        tx_pin_out[t] <= gpio_out[t];
        tx_pin_oe[t] <= gpio_oe[t];
      end
    end

    // phy stays in reset until the adapter is enabled and the ethernet layer lets it go
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        phy_reset_n[t] <= 1'b0;
      else
        phy_reset_n[t] <= adapter_enable[t] && phy_release[t];
    end

    // receive pin levels for general purpose reads
    rgb_sync #(.W(`RGB_RXPIN_W)) u_gpio_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({receive_control[t], receive_nibble[t]}),
      .q(gpio_in[t])
    );

    // receive link domain
    logic [1:0] lrst_r;
    logic lrst_n;
    logic [`RGB_NIB_W-1:0] lo_r;
    logic [`RGB_NIB_W-1:0] hi_r;
    logic vlo_r;
    logic vhi_r;
    logic prev_valid_r;
    logic req_r;
    logic end_tog_r;
    logic [`RGB_BYTE_W-1:0] hold_word_r;
    logic hold_err_r;
    logic ack_s;

    always_ff @(posedge rx_link_clk[t] or negedge reset_n)
    begin
      if (!reset_n)
        lrst_r <= 2'h0;
      else
        lrst_r <= {lrst_r[0], 1'b1};
    end
    assign lrst_n = lrst_r[1];

    // falling edge: high nibble and valid xor error
    always_ff @(negedge rx_link_clk[t] or negedge lrst_n)
    begin
      if (!lrst_n)
      begin
        hi_r <= 4'h0;
        vhi_r <= 1'b0;
      end
      else
      begin
        hi_r <= receive_nibble[t];
        vhi_r <= receive_control[t];
      end
    end

    // rising edge: low nibble and valid; previous full word handed over
    always_ff @(posedge rx_link_clk[t] or negedge lrst_n)
    begin
      if (!lrst_n)
      begin
        lo_r <= 4'h0;
        vlo_r <= 1'b0;
        prev_valid_r <= 1'b0;
        req_r <= 1'b0;
        end_tog_r <= 1'b0;
        hold_word_r <= 8'h00;
        hold_err_r <= 1'b0;
      end
      else
      begin
        lo_r <= receive_nibble[t];
        vlo_r <= receive_control[t];
        prev_valid_r <= vlo_r;
        if (prev_valid_r && !vlo_r)
          end_tog_r <= !end_tog_r;
        // words arriving while the previous one is unclaimed are dropped
        if (vlo_r && (ack_s == req_r))
        begin
          hold_word_r <= {hi_r, lo_r};
          hold_err_r <= vlo_r ^ vhi_r;
          req_r <= !req_r;
        end
      end
    end

    // system domain side of the receive handshake
    logic req_s;
    logic end_s;
    logic req_seen_r;
    logic end_seen_r;
    logic ack_r;

    rgb_sync #(.W(2)) u_req_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({req_r, end_tog_r}),
      .q({req_s, end_s})
    );

    rgb_sync #(.W(1)) u_ack_sync (
      .clk(rx_link_clk[t]),
      .reset_n(lrst_n),
      .d(ack_r),
      .q(ack_s)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        req_seen_r <= 1'b0;
        end_seen_r <= 1'b0;
        ack_r <= 1'b0;
        rx_word[t] <= 8'h00;
        rx_valid[t] <= 1'b0;
        rx_error[t] <= 1'b0;
        rx_strobe[t] <= 1'b0;
        rx_frame_end[t] <= 1'b0;
      end
      else
      begin
        req_seen_r <= req_s;
        end_seen_r <= end_s;
        rx_strobe[t] <= 1'b0;
        rx_frame_end[t] <= adapter_enable[t] && (end_s != end_seen_r);
        if (req_s != req_seen_r)
        begin
          ack_r <= req_s;
          if (adapter_enable[t])
          begin
            rx_word[t] <= hold_word_r;
            rx_valid[t] <= 1'b1;
            rx_error[t] <= hold_err_r;
            rx_strobe[t] <= 1'b1;
          end
        end
        if (!adapter_enable[t])
        begin
          rx_word[t] <= 8'h00;
          rx_valid[t] <= 1'b0;
          rx_error[t] <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== hdl/rgb_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module rgb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== include/rgb_map.svh
// constants and register-free mapping for the dual gigabit ddr/sdr bridge
`ifndef RGB_MAP_SVH
`define RGB_MAP_SVH
`define RGB_TILES 2
`define RGB_NIB_W 4
`define RGB_BYTE_W 8
`define RGB_TXPIN_W 6
`define RGB_RXPIN_W 5
`define RGB_PIN_CLK 5
`define RGB_PIN_CTL 4
`define RGB_OE_ALL 6'h3F
`define RGB_SYNC_STAGES 2
`endif

// ===== include/rgb_pkg.sv
// types shared by the dual gigabit ddr/sdr bridge
package rgb_pkg;
  // four system clock phases make one transmit clock period
  typedef enum logic [1:0] {PH_LO0, PH_LO1, PH_HI0, PH_HI1} rgb_phase_t;
endpackage

// ===== tb/rgb_bridge_checker.sv
// port assertions for the ddr/sdr bridge
`timescale 1ns/1ps
module rgb_bridge_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // setup and transmit side
  input wire logic [1:0] adapter_enable,
  input wire logic [1:0] tx_clock_run,
  input wire logic [1:0] tx_clock_delay,
  input wire logic [1:0] phy_release,
  input wire logic [1:0][7:0] tx_word,
  input wire logic [1:0] tx_valid,
  input wire logic [1:0] tx_error,
  input wire logic [1:0] tx_take,
  input wire logic [1:0][5:0] gpio_oe,
  // pins and receive side
  input wire logic [1:0][5:0] tx_pin_out,
  input wire logic [1:0][5:0] tx_pin_oe,
  input wire logic [1:0] phy_reset_n,
  input wire logic [1:0][7:0] rx_word,
  input wire logic [1:0] rx_strobe,
  input wire logic [1:0] rx_frame_end
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_phy_reset: assert property (phy_reset_n == $past(adapter_enable & phy_release))
    else $error("phy reset wrong");
  chk_take_gap: assert property (tx_take[0] |=> !tx_take[0] [*3])
    else $error("take spacing wrong");
  chk_gpio_mux: assert property (!adapter_enable[0] |=> tx_pin_oe[0] == $past(gpio_oe[0]))
    else $error("gpio enable not passed");
  chk_run_off: assert property (adapter_enable[0] && !tx_clock_run[0] |=>
    tx_pin_out[0] == 6'h00 && tx_pin_oe[0] == 6'h3F) else $error("idle pins wrong");
  chk_low_nibble: assert property (tx_take[0] |->
    tx_pin_out[0][4:0] == {$past(tx_valid[0]), $past(tx_word[0][3:0])})
    else $error("low nibble wrong");
  chk_high_nibble: assert property (tx_take[0] ##1 tx_clock_run[0] [*2] |->
    tx_pin_out[0][4:0] == {$past(tx_valid[0] ^ tx_error[0], 3), $past(tx_word[0][7:4], 3)})
    else $error("high nibble wrong");
  chk_clock_lag: assert property (tx_take[0] |->
    tx_pin_out[0][5] == !tx_clock_delay[0] ##1 tx_pin_out[0][5]) else $error("clock phase wrong");
  chk_rx_clear: assert property (!adapter_enable[0] [*2] |->
    rx_word[0] == 8'h00 && !rx_strobe[0]) else $error("receive not cleared");
  cov_tx_delay: cover property (tx_take[0] && tx_clock_delay[0]);
  cov_rx_word: cover property (rx_strobe[1]);
  cov_frame_end: cover property (rx_frame_end[0]);
endmodule
bind rgb_bridge rgb_bridge_checker chk_u (
  .clk(clk), .reset_n(reset_n), .adapter_enable(adapter_enable),
  .tx_clock_run(tx_clock_run), .tx_clock_delay(tx_clock_delay), .phy_release(phy_release),
  .tx_word(tx_word), .tx_valid(tx_valid), .tx_error(tx_error), .tx_take(tx_take),
  .gpio_oe(gpio_oe), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
  .phy_reset_n(phy_reset_n), .rx_word(rx_word), .rx_strobe(rx_strobe),
  .rx_frame_end(rx_frame_end)
);

// ===== tb/rgb_bridge_test.sv
// self-checking bench for the dual ddr/sdr bridge
`timescale 1ns/1ps
module rgb_bridge_test;
  logic clk;
  logic reset_n;
  logic [1:0] adapter_enable, tx_clock_run, tx_clock_delay, phy_release, tx_valid, tx_error;
  logic [1:0] tx_take, rx_valid, rx_error, rx_strobe, rx_frame_end, phy_reset_n;
  logic [1:0] rx_link_clk, receive_control;
  logic [1:0][7:0] tx_word, rx_word;
  logic [1:0][5:0] gpio_out, gpio_oe, tx_pin_out, tx_pin_oe;
  logic [1:0][4:0] gpio_in;
  logic [1:0][3:0] receive_nibble;
  int failures;
  int check_count;
  rgb_bridge dut_u (
    .clk(clk), .reset_n(reset_n), .adapter_enable(adapter_enable),
    .tx_clock_run(tx_clock_run), .tx_clock_delay(tx_clock_delay), .phy_release(phy_release),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_error(tx_error), .tx_take(tx_take),
    .rx_word(rx_word), .rx_valid(rx_valid), .rx_error(rx_error), .rx_strobe(rx_strobe),
    .rx_frame_end(rx_frame_end), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_link_clk(rx_link_clk),
    .receive_control(receive_control), .receive_nibble(receive_nibble),
    .phy_reset_n(phy_reset_n)
  );
  rgb_phy_model phy_u (
    .rx_link_clk(rx_link_clk), .receive_control(receive_control),
    .receive_nibble(receive_nibble)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // about twenty times the expected run
  initial
  begin
    #300000;
    failures++;
    stop_test;
  end
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_gpio;
    @(posedge clk);
    adapter_enable <= 2'b10;
    phy_release <= 2'b11;
    gpio_out <= {6'h2A, 6'h15};
    gpio_oe <= {6'h3C, 6'h0F};
    tick(4);
    chk("gpio out", 8'(tx_pin_out[0]), 8'h15);
    chk("gpio oe", 8'(tx_pin_oe[0]), 8'h0F);
    chk("gpio in", 8'(gpio_in[0]), 8'h0A);
    chk("other oe", 8'(tx_pin_oe[1]), 8'h3F);
    chk("phy rst", 8'(phy_reset_n), 8'h02);
  endtask
  task automatic t_tx(input int t, input logic d, input logic e);
    logic [7:0] b;
    b = {t[0], d, e, 5'h16};
    @(posedge clk);
    adapter_enable[t] <= 1'b1;
    tx_clock_run[t] <= 1'b1;
    tx_clock_delay[t] <= d;
    tx_word[t] <= b;
    tx_valid[t] <= 1'b1;
    tx_error[t] <= e;
    tick(1);
    chk("take", 8'(tx_take[t]), 8'h01);
    chk("low", 8'(tx_pin_out[t]), {2'b00, !d, 1'b1, b[3:0]});
    tick(2);
    chk("high", 8'(tx_pin_out[t]), {2'b00, d, !e, b[7:4]});
    chk("drive", 8'(tx_pin_oe[t]), 8'h3F);
    @(posedge clk);
    tx_clock_run[t] <= 1'b0;
    tick(2);
    chk("idle out", 8'(tx_pin_out[t]), 8'h00);
  endtask
  task automatic t_rx(input int t, input logic [7:0] b, input logic e);
    @(posedge clk);
    adapter_enable[t] <= 1'b1;
    fork
      phy_u.send(t, b, e);
      begin
        tick(1);
        for (int i = 0; i < 60 && rx_strobe[t] !== 1'b1; i++)
          tick(1);
        chk("rx word", rx_word[t], b);
        chk("rx err", 8'(rx_error[t]), 8'(e));
        chk("rx valid", 8'(rx_valid[t]), 8'h01);
        for (int i = 0; i < 60 && rx_frame_end[t] !== 1'b1; i++)
          tick(1);
        chk("frame end", 8'(rx_frame_end[t]), 8'h01);
      end
    join
  endtask
  task automatic t_off;
    @(posedge clk);
    adapter_enable <= 2'b00;
    tick(2);
    chk("rx cleared", rx_word[0], 8'h00);
    chk("valid cleared", 8'(rx_valid[0]), 8'h00);
    chk("phy held", 8'(phy_reset_n), 8'h00);
    chk("gpio back", 8'(tx_pin_out[1]), 8'h2A);
    chk("gpio oe back", 8'(tx_pin_oe[1]), 8'h3C);
  endtask
  initial
  begin
    failures = 0;
    check_count = 0;
    reset_n = 1'b1;
    {adapter_enable, tx_clock_run, tx_clock_delay, phy_release, tx_valid, tx_error} = 12'h000;
    tx_word = 16'h0000;
    gpio_out = 12'h000;
    gpio_oe = 12'h000;
    // a definite falling edge, so the link side resets as well
    #1;
    reset_n = 1'b0;
    tick(20);
    chk("reset phy", 8'(phy_reset_n), 8'h00);
    @(posedge clk);
    reset_n <= 1'b1;
    t_gpio;
    for (int i = 0; i < 8; i++)
      t_tx(i / 4, i[1], i[0]);
    for (int i = 0; i < 4; i++)
      t_rx(i % 2, 8'h3C ^ 8'(i * 85), i[1]);
    t_off;
    stop_test;
  end
endmodule

// ===== tb/rgb_phy_model.sv
// phy model driving the ddr receive pins of both tiles
`timescale 1ns/1ps
module rgb_phy_model (
  // ddr receive pins
  output logic [1:0] rx_link_clk,
  output logic [1:0] receive_control,
  output logic [1:0][3:0] receive_nibble
);
  initial
  begin
    rx_link_clk = 2'b00;
    receive_control = 2'b00;
    receive_nibble = 8'h5A;
  end
  // one 30 ns cycle, data set a quarter period ahead of each edge
  task automatic cyc(input int t, input logic [7:0] b, input logic v, input logic e);
    receive_nibble[t] = b[3:0];
    receive_control[t] = v;
    #7.5 rx_link_clk[t] = 1'b1;
    #7.5 receive_nibble[t] = b[7:4];
    receive_control[t] = v ^ e;
    #7.5 rx_link_clk[t] = 1'b0;
    #7.5;
  endtask
  // idle cycles around one word let the link reset and handshake settle
  task automatic send(input int t, input logic [7:0] b, input logic e);
    for (int i = 0; i < 36; i++)
      cyc(t, i == 4 ? b : 8'(i * 23), i == 4, i == 4 && e);
    receive_nibble[t] = ~b[7:4];
  endtask
endmodule
